// *** core/tx_line_overhead_regs.vh ***
`ifndef TX_LINE_OVERHEAD_REGS_VH
`define TX_LINE_OVERHEAD_REGS_VH

// Register byte addresses
`define TLO_ADDR_CONFIG 8'h00
`define TLO_ADDR_CONTROL 8'h04
`define TLO_ADDR_K1 8'h08
`define TLO_ADDR_K2 8'h0C
`define TLO_ADDR_STATUS 8'h10

// Reset values
`define TLO_CTRL_RESET 8'h00
`define TLO_CFG_RESET 2'h0
`define TLO_K_RESET 8'h00

// Control register bit positions
`define TLO_CTRL_DEFECT 0
`define TLO_CTRL_OW_PASS 1
`define TLO_CTRL_DCC_PASS 2
`define TLO_CTRL_PROT_PASS 3
`define TLO_CTRL_GROWTH_PASS 4
`define TLO_CTRL_SRC_SEL 5
`define TLO_CTRL_UNUSED_PASS 6
`define TLO_CTRL_PARITY_PASS 7

// Config register bit positions
`define TLO_CFG_RATE 0
`define TLO_CFG_RING 1

// Frame geometry, zero-based rows and column groups
`define TLO_ROW_LINE_FIRST 4'h3
`define TLO_ROW_APS 4'h4
`define TLO_ROW_DCC_FIRST 4'h5
`define TLO_ROW_DCC_LAST 4'h7
`define TLO_ROW_GROWTH 4'h8
`define TLO_ROW_LAST 4'h8
`define TLO_ROW_FIRST 4'h0
`define TLO_COL_FIRST 7'h00
`define TLO_COL_B2 7'h00
`define TLO_COL_K1 7'h01
`define TLO_COL_K2 7'h02
`define TLO_COL_Z2 7'h01
`define TLO_COL_E2 7'h02
`define TLO_COL_TOH_LAST 7'h02
`define TLO_COL_LAST 7'h59
`define TLO_STS_FIRST 2'h0
`define TLO_STS3_LAST 2'h2

// Inserted codes and serial framing
`define TLO_DEFECT_CODE 3'h6
`define TLO_SER_BIT_LAST 3'h7
`define TLO_PROT_BIT_LAST 4'hF

`endif

// *** core/tx_line_overhead_insertion.v ***
// Functional notes
// R1: Line defect insert bit forces 110 into K2 bits 6 to 8.
// R2: Defect also forced by discrete pin, or ring port when ring enabled.
// R3: With no defect request, K2 bits 6 to 8 stay as selected.
// R4: Orderwire pass bit passes the E2 input byte unaltered.
// R5: STS-3 unused orderwire positions zeroed unless strobe, overhead port enable or unused pass.
// R6: Orderwire pass clear: E2 comes from serial orderwire input.
// R7: Data channel pass bit passes D4 to D12 input bytes unaltered.
// R8: STS-3 unused data channel positions zeroed unless strobe, overhead port enable or unused pass.
// R9: Data channel pass clear: D4 to D12 come from serial data input.
// R10: Protection pass passes K1/K2; STS-3 unused K positions zeroed.
// R11: Protection pass clear: K1/K2 from serial input or K registers.
// R12: Growth pass bit passes every Z2 byte unaltered.
// R13: Growth pass clear: Z2 carries far-end error count and zeros.
// R14: Source select zero uses serial protection input, one uses K registers.
// R15: Pass-through strobe outranks the selected protection source.
// R16: STS-3 K1, K2, D4-D12, E2 of STS-1 #2 and #3 are unused.
// R17: Unused positions zero, or passed when unused pass bit set.
// R18: Parity pass passes B2, otherwise computed line parity inserted.
// R19: Rate select 0 is STS-1, 1 is STS-3 interleave.
// R20: Ring enable picks ring port or discrete pin for defect request.
// R21: Row, column, STS counters synced to frame pulse locate each byte.
`timescale 1ns/1ps
`include "tx_line_overhead_regs.vh"

module tx_line_overhead_insertion (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire txByteValid,
  input wire txFrameStart,
  input wire [7:0] txByteIn,
  input wire bytePassThroughStrobe,
  input wire txOverheadPortEnable,
  input wire serialOverheadBitStrobe,
  input wire serialOrderwireInput,
  input wire serialLineDataChannelInput,
  input wire serialProtectionInput,
  input wire serialProtectionClock,
  input wire remoteDefectForceInput,
  input wire ringDefectRequest,
  input wire [3:0] farEndErrorCount,
  output reg [7:0] txByteOut_q,
  output reg txByteOutValid_q,
  output reg txFrameOut_q
);

  ////////////////////////////////////////////////////////////////////////
  // Register file
  reg [7:0] ctrl_q;
  reg [1:0] cfg_q;
  reg [7:0] k1Shadow_q;
  reg [7:0] k2Shadow_q;
  reg [7:0] k1Active_q;
  reg [7:0] k2Active_q;
  reg kPending_q;
  reg [3:0] rowIdx_q;
  reg [6:0] colIdx_q;
  reg [1:0] stsIdx_q;
  reg [31:0] rdData;
  reg addrHit;

  wire setupPhase = psel & ~penable;
  wire accessPhase = psel & penable;
  wire wrEn = accessPhase & pwrite & addrHit;
  wire frameTick = txByteValid & txFrameStart;

  assign pready = 1'b1;
  assign pslverr = accessPhase & ~addrHit;

  always @* begin
    addrHit = 1'b1;
    rdData = 32'h00000000;
    case (paddr)
      `TLO_ADDR_CONFIG: rdData[1:0] = cfg_q;
      `TLO_ADDR_CONTROL: rdData[7:0] = ctrl_q;
      `TLO_ADDR_K1: rdData[7:0] = k1Shadow_q;
      `TLO_ADDR_K2: rdData[7:0] = k2Shadow_q;
      `TLO_ADDR_STATUS: rdData[13:0] =
        {kPending_q, stsIdx_q, colIdx_q, rowIdx_q};
      default: addrHit = 1'b0;
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (setupPhase) begin
      prdata <= rdData;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= `TLO_CTRL_RESET;
      cfg_q <= `TLO_CFG_RESET;
      k1Shadow_q <= `TLO_K_RESET;
      k2Shadow_q <= `TLO_K_RESET;
    end else if (wrEn) begin
      if (paddr == `TLO_ADDR_CONTROL) begin
        ctrl_q <= pwdata[7:0];
      end
      if (paddr == `TLO_ADDR_CONFIG) begin
        cfg_q <= pwdata[1:0];
      end
      if (paddr == `TLO_ADDR_K1) begin
        k1Shadow_q <= pwdata[7:0];
      end
      if (paddr == `TLO_ADDR_K2) begin
        k2Shadow_q <= pwdata[7:0];
      end
    end
  end

  // K1 write arms the pair; both move at the next frame boundary
  wire k1Write = wrEn & (paddr == `TLO_ADDR_K1);
  always @(posedge core_clk) begin
    if (srst) begin
      k1Active_q <= `TLO_K_RESET;
      k2Active_q <= `TLO_K_RESET;
      kPending_q <= 1'b0;
    end else begin
      if (frameTick & kPending_q) begin
        k1Active_q <= k1Shadow_q;
        k2Active_q <= k2Shadow_q;
      end
      if (k1Write) begin
        kPending_q <= 1'b1;
      end else if (frameTick) begin
        kPending_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame position
  wire sts3 = cfg_q[`TLO_CFG_RATE]; // see R19
  // Frame start forces position zero, so a slipped count resyncs
  wire [3:0] curRow = txFrameStart ? `TLO_ROW_FIRST : rowIdx_q; // see R21
  wire [6:0] curCol = txFrameStart ? `TLO_COL_FIRST : colIdx_q;
  wire [1:0] curSts = txFrameStart ? `TLO_STS_FIRST : stsIdx_q;
  wire stsWrap = ~sts3 | (curSts >= `TLO_STS3_LAST);
  wire colWrap = curCol >= `TLO_COL_LAST;

  always @(posedge core_clk) begin
    if (srst) begin
      rowIdx_q <= `TLO_ROW_FIRST;
      colIdx_q <= `TLO_COL_FIRST;
      stsIdx_q <= `TLO_STS_FIRST;
    end else if (txByteValid) begin
      if (!stsWrap) begin
        stsIdx_q <= curSts + 2'h1; // see R21
        rowIdx_q <= curRow;
        colIdx_q <= curCol;
      end else begin
        stsIdx_q <= `TLO_STS_FIRST;
        if (!colWrap) begin
          colIdx_q <= curCol + 7'h01;
          rowIdx_q <= curRow;
        end else begin
          colIdx_q <= `TLO_COL_FIRST;
          rowIdx_q <= (curRow >= `TLO_ROW_LAST) ? `TLO_ROW_FIRST
                                                 : curRow + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial orderwire and data channel bytes
  wire [1:0] serBit = {serialLineDataChannelInput, serialOrderwireInput};
  wire [15:0] serHoldAll;

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : gSer
      reg [7:0] shift_q;
      reg [2:0] count_q;
      reg [7:0] hold_q;
      always @(posedge core_clk) begin
        if (srst) begin
          shift_q <= 8'h00;
          count_q <= 3'h0;
          hold_q <= 8'h00;
        end else if (serialOverheadBitStrobe) begin
          shift_q <= {shift_q[6:0], serBit[c]};
          count_q <= count_q + 3'h1;
          if (count_q == `TLO_SER_BIT_LAST) begin
            hold_q <= {shift_q[6:0], serBit[c]};
          end
        end
      end
      assign serHoldAll[c*8 +: 8] = hold_q;
    end
  endgenerate

  wire [7:0] owSerialByte = serHoldAll[7:0];
  wire [7:0] dccSerialByte = serHoldAll[15:8];

  ////////////////////////////////////////////////////////////////////////
  // Serial protection channel, K1 then K2, MSB first
  reg protClkPrev_q;
  reg [15:0] protShift_q;
  reg [3:0] protCount_q;
  reg [15:0] protHold_q;
  // Pin idles low, matching the reset value, so no false edge
  wire protEdge = serialProtectionClock & ~protClkPrev_q;

  always @(posedge core_clk) begin
    if (srst) begin
      protClkPrev_q <= 1'b0;
      protShift_q <= 16'h0000;
      protCount_q <= 4'h0;
      protHold_q <= 16'h0000;
    end else begin
      protClkPrev_q <= serialProtectionClock;
      if (protEdge) begin // see R14
        protShift_q <= {protShift_q[14:0], serialProtectionInput};
        protCount_q <= protCount_q + 4'h1;
        if (protCount_q == `TLO_PROT_BIT_LAST) begin
          protHold_q <= {protShift_q[14:0], serialProtectionInput};
        end
      end
    end
  end

  wire srcReg = ctrl_q[`TLO_CTRL_SRC_SEL];
  wire [7:0] k1Source = srcReg ? k1Active_q : protHold_q[15:8]; // see R14
  wire [7:0] k2Source = srcReg ? k2Active_q : protHold_q[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Line parity per STS-1
  reg [7:0] outByte;
  wire [23:0] bipHoldAll;
  // Parity covers every byte except the section overhead
  wire inLine = (curRow >= `TLO_ROW_LINE_FIRST) |
                (curCol > `TLO_COL_TOH_LAST);

  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1) begin : gBip
      reg [7:0] acc_q;
      reg [7:0] hold_q;
      always @(posedge core_clk) begin
        if (srst) begin
          acc_q <= 8'h00;
          hold_q <= 8'h00;
        end else if (frameTick) begin
          hold_q <= acc_q;
          acc_q <= 8'h00;
        end else if (txByteValid & inLine & (curSts == s)) begin
          acc_q <= acc_q ^ outByte;
        end
      end
      assign bipHoldAll[s*8 +: 8] = hold_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Byte selection
  wire defectReq = cfg_q[`TLO_CFG_RING] ? ringDefectRequest // see R20
                                        : remoteDefectForceInput;
  wire defectOn = ctrl_q[`TLO_CTRL_DEFECT] | defectReq; // see R2
  wire bypass = bytePassThroughStrobe | txOverheadPortEnable;
  wire inToh = curCol <= `TLO_COL_TOH_LAST;
  wire stsOther = sts3 & (curSts != `TLO_STS_FIRST);
  wire atAps = inToh & (curRow == `TLO_ROW_APS);
  wire atK1 = atAps & (curCol == `TLO_COL_K1);
  wire atK2 = atAps & (curCol == `TLO_COL_K2);
  wire atB2 = atAps & (curCol == `TLO_COL_B2);
  wire atDcc = inToh & (curRow >= `TLO_ROW_DCC_FIRST) &
               (curRow <= `TLO_ROW_DCC_LAST);
  wire atGrow = inToh & (curRow == `TLO_ROW_GROWTH);
  wire atZ2 = atGrow & (curCol == `TLO_COL_Z2);
  wire atE2 = atGrow & (curCol == `TLO_COL_E2);
  wire atUnused = stsOther & (atK1 | atK2 | atDcc | atE2); // see R16
  wire [7:0] unusedByte =
    ctrl_q[`TLO_CTRL_UNUSED_PASS] ? txByteIn : 8'h00; // see R17

  always @* begin
    outByte = txByteIn;
    if (!bypass) begin // see R15
      if (atUnused) begin
        outByte = unusedByte; // see R5 see R8 see R10
      end else if (atB2) begin
        if (!ctrl_q[`TLO_CTRL_PARITY_PASS]) begin
          outByte = bipHoldAll[curSts*8 +: 8]; // see R18
        end
      end else if (atK1) begin
        if (!ctrl_q[`TLO_CTRL_PROT_PASS]) begin
          outByte = k1Source; // see R11
        end
      end else if (atK2) begin
        if (!ctrl_q[`TLO_CTRL_PROT_PASS]) begin
          outByte = k2Source; // see R10 see R11
        end
      end else if (atDcc) begin
        if (!ctrl_q[`TLO_CTRL_DCC_PASS]) begin
          outByte = dccSerialByte; // see R7 see R9
        end
      end else if (atE2) begin
        if (!ctrl_q[`TLO_CTRL_OW_PASS]) begin
          outByte = owSerialByte; // see R4 see R6
        end
      end else if (atZ2) begin
        if (!ctrl_q[`TLO_CTRL_GROWTH_PASS]) begin // see R12
          outByte = (curSts == `TLO_STS_FIRST) ? // see R13
                    {4'h0, farEndErrorCount} : 8'h00;
        end
      end
    end
    // Defect code overlays every defined K2, other bits kept
    if (atK2 & ~stsOther & defectOn) begin // see R3
      outByte[2:0] = `TLO_DEFECT_CODE; // see R1
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage
  always @(posedge core_clk) begin
    if (srst) begin
      txByteOut_q <= 8'h00;
      txByteOutValid_q <= 1'b0;
      txFrameOut_q <= 1'b0;
    end else begin
      txByteOutValid_q <= txByteValid;
      txFrameOut_q <= frameTick;
      if (txByteValid) begin
        txByteOut_q <= outByte;
      end
    end
  end

endmodule

// *** dv/tx_line_overhead_props.sv ***
`timescale 1ns/1ps
module tx_line_overhead_props (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire txByteValid,
  input wire txFrameStart,
  input wire [7:0] txByteIn,
  input wire bytePassThroughStrobe,
  input wire [7:0] txByteOut_q,
  input wire txByteOutValid_q,
  input wire txFrameOut_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire acc = psel && penable;
  a_valid_delay: assert property (txByteValid |=> txByteOutValid_q)
    else $error("output valid lost");
  a_no_extra: assert property (!txByteValid |=> !txByteOutValid_q)
    else $error("output valid without input");
  a_frame_delay: assert property (
    txFrameStart && txByteValid |=> txFrameOut_q && txByteOutValid_q)
    else $error("frame marker lost");
  a_strobe_pass: assert property (
    txByteValid && bytePassThroughStrobe |=>
    txByteOut_q[7:3] == $past(txByteIn[7:3]))
    else $error("strobed byte altered");
  a_hold_out: assert property (!txByteValid |=> $stable(txByteOut_q))
    else $error("output byte moved while idle");
  a_ready_high: assert property (acc |-> pready)
    else $error("bus ready low");
  a_err_unmapped: assert property (acc && paddr > 8'h10 |-> pslverr)
    else $error("no error on unmapped address");
  a_ok_control: assert property (acc && paddr == 8'h04 |-> !pslverr)
    else $error("error on control register");
endmodule

bind tx_line_overhead_insertion tx_line_overhead_props props_u (
  .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .txByteValid(txByteValid), .txFrameStart(txFrameStart),
  .txByteIn(txByteIn), .bytePassThroughStrobe(bytePassThroughStrobe),
  .txByteOut_q(txByteOut_q), .txByteOutValid_q(txByteOutValid_q),
  .txFrameOut_q(txFrameOut_q)
);

// *** dv/tx_byte_source.sv ***
`timescale 1ns/1ps
module tx_byte_source (
  input wire core_clk,
  input wire srst,
  input wire sts3,
  input wire strobeK1,
  output wire txByteValid,
  output wire txFrameStart,
  output wire [7:0] txByteIn,
  output wire bytePassThroughStrobe
);
  reg [11:0] idx_q;
  reg [4:0] tick_q;
  // Idle cycle every 32, byte inverted while idle
  assign txByteValid = !srst && tick_q != 5'h1F;
  assign txFrameStart = txByteValid && idx_q == 12'h000;
  assign txByteIn = {8{txByteValid}} ~^ (idx_q[7:0] ^ 8'hA5);
  assign bytePassThroughStrobe = strobeK1 && idx_q == 12'h169;
  always @(posedge core_clk) begin
    tick_q <= srst ? 5'h00 : tick_q + 5'h01;
    if (srst || txByteValid && idx_q >= (sts3 ? 12'h97D : 12'h329)) begin
      idx_q <= 12'h000;
    end else if (txByteValid) begin
      idx_q <= idx_q + 12'h001;
    end
  end
endmodule

// *** dv/tx_line_overhead_insertion_tb.sv ***
`timescale 1ns/1ps
module tx_line_overhead_insertion_tb;
  logic core_clk = 0;
  logic srst = 1;
  logic psel = 0, penable = 0, pwrite = 0, sts3 = 0, strobeK1 = 0;
  logic defForce = 0, ringReq = 0, serStb = 0, serOw = 0, serDc = 0;
  logic ohEn = 0, serPd = 0, serPc = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdData;
  logic rdErr;
  wire pready, pslverr, vld, fs, stb, ovld, ofs;
  wire [31:0] prdata;
  wire [7:0] din, dout;
  logic [7:0] ob [0:2429];
  logic [23:0] bipAcc = 24'h0, bipPrev = 24'h0, bipOld = 24'h0;
  int outIdx = 0, frames = 0, miscompares = 0, numChecks = 0;
  int pp[7] = '{360, 361, 362, 450, 632, 721, 722};
  int uu[3] = '{1084, 1351, 2168};
  always #5 core_clk = ~core_clk;
  tx_line_overhead_insertion dut_u (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .txByteValid(vld),
    .txFrameStart(fs), .txByteIn(din), .bytePassThroughStrobe(stb),
    .txOverheadPortEnable(ohEn), .serialOverheadBitStrobe(serStb),
    .serialOrderwireInput(serOw), .serialLineDataChannelInput(serDc),
    .serialProtectionInput(serPd), .serialProtectionClock(serPc),
    .remoteDefectForceInput(defForce), .ringDefectRequest(ringReq),
    .farEndErrorCount(4'h9), .txByteOut_q(dout), .txByteOutValid_q(ovld),
    .txFrameOut_q(ofs)
  );
  tx_byte_source src_u (
    .core_clk(core_clk), .srst(srst), .sts3(sts3), .strobeK1(strobeK1),
    .txByteValid(vld), .txFrameStart(fs), .txByteIn(din),
    .bytePassThroughStrobe(stb)
  );
  // Everything but section overhead counts towards line parity
  function automatic bit isLine(input int p, input int n);
    return p / (90 * n) >= 3 || p % (90 * n) / n >= 3;
  endfunction
  // Capture of the outgoing frame by position, with per-STS parity
  always @(posedge core_clk) if (ovld) begin
    outIdx = ofs ? 0 : outIdx + 1;
    frames = frames + ofs;
    if (ofs) begin
      bipOld = bipPrev;
      bipPrev = bipAcc;
      bipAcc = 24'h0;
    end else if (isLine(outIdx, sts3 ? 3 : 1)) begin
      bipAcc[8 * (outIdx % (sts3 ? 3 : 1)) +: 8] ^= dout;
    end
    if (outIdx < 2430) ob[outIdx] = dout;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] inb(input int p);
    return 8'(p) ^ 8'hA5;
  endfunction
  task reportAndStop();
    $display("checks %0d, mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge core_clk);
    if (pready !== 1'b1) begin
      miscompares++;
      reportAndStop();
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  task waitFrames(input int n);
    int t, k;
    t = frames + n;
    for (k = 0; k < 6000 * n && frames < t; k++) @(posedge core_clk);
    if (frames < t) begin
      miscompares++;
      reportAndStop();
    end
  endtask
  task serialByte(input logic [7:0] ow, input logic [7:0] dc);
    for (int b = 7; b >= 0; b--) begin
      serOw <= ow[b];
      serDc <= dc[b];
      serStb <= 1;
      @(posedge core_clk);
      serStb <= 0;
      @(posedge core_clk);
    end
  endtask
  // Data set while the clock is low, shifted on its rising edge
  task serialProt(input logic [15:0] kk);
    for (int b = 15; b >= 0; b--) begin
      serPd <= kk[b];
      @(posedge core_clk);
      serPc <= 1;
      @(posedge core_clk);
      serPc <= 0;
    end
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 0;
    xfer(0, 8'h04, 0);
    check(rdData, 32'h0);
    xfer(1, 8'h04, 32'h5A);
    xfer(0, 8'h04, 0);
    check(rdData, 32'h5A);
    xfer(0, 8'h14, 0);
    check(rdErr, 1'b1);
    $display("test regs done");
    xfer(1, 8'h04, 32'hDE);
    waitFrames(2);
    foreach (pp[k]) check(ob[pp[k]], inb(pp[k]));
    $display("test pass bits done");
    // Defect from control bit, discrete pin, ring port, masked pin
    for (int m = 0; m < 4; m++) begin
      xfer(1, 8'h00, {30'h0, m >= 2, 1'b0});
      xfer(1, 8'h04, m == 0 ? 32'hDF : 32'hDE);
      defForce <= m == 1 || m == 3;
      ringReq <= m == 2;
      waitFrames(2);
      check(ob[362], m == 3 ? inb(362)
                            : inb(362) & 8'hF8 | 8'h06);
    end
    defForce <= 0;
    ringReq <= 0;
    $display("test defect done");
    xfer(1, 8'h00, 0);
    xfer(1, 8'h04, 32'h20);
    xfer(1, 8'h0C, 32'h3C);
    xfer(1, 8'h08, 32'hC3);
    serialByte(8'h96, 8'h69);
    waitFrames(2);
    check(ob[361], 8'hC3);
    check(ob[362], 8'h3C);
    check(ob[722], 8'h96);
    check(ob[450], 8'h69);
    check(ob[721], 8'h09);
    check(ob[360], bipOld[7:0]);
    strobeK1 <= 1;
    waitFrames(2);
    check(ob[361], inb(361));
    strobeK1 <= 0;
    ohEn <= 1;
    waitFrames(2);
    check(ob[722], inb(722));
    check(ob[450], inb(450));
    ohEn <= 0;
    xfer(1, 8'h04, 32'h00);
    serialProt(16'hA55A);
    waitFrames(2);
    check(ob[361], 8'hA5);
    check(ob[362], 8'h5A);
    $display("test inserted bytes done");
    xfer(1, 8'h00, 1);
    sts3 <= 1;
    for (int u = 0; u < 2; u++) begin
      xfer(1, 8'h04, u ? 32'h5E : 32'h1E);
      waitFrames(2);
      foreach (uu[k]) check(ob[uu[k]], u ? inb(uu[k]) : 8'h00);
      check(ob[1083], inb(1083));
      check(ob[2165], inb(2165));
    end
    $display("test sts3 done");
    reportAndStop();
  end
endmodule
